// ### shared/irq_unit_params.svh
// Constants of the two-level vectored interrupt unit.
// Assumes inclusion by bare name from design files only.
`ifndef IRQ_UNIT_PARAMS_SVH
`define IRQ_UNIT_PARAMS_SVH

// Register byte offsets
`define OFS_BASIC_EN    8'h00
`define OFS_EXT_EN_ONE  8'h04
`define OFS_EXT_EN_TWO  8'h08
`define OFS_BASIC_PRI   8'h0C
`define OFS_EXT_PRI_ONE 8'h10
`define OFS_EXT_PRI_TWO 8'h14
`define OFS_PENDING     8'h18
`define OFS_STATUS      8'h1C

// Field positions
`define GLOBAL_EN_BIT   7
`define PRI_UNUSED_BIT  7
`define RSVD_ORDER_A    8
`define RSVD_ORDER_B    15
`define HW_CLR_LAST     3

// Reset values
`define EN_RESET        8'h00
`define PRI_RESET       8'h00
`define PEND_RESET      16'h0000

// Vectors
`define RESET_VECTOR    16'h0000
`define VECTOR_BASE     16'h0003

// Timing
`define LONG_CALL_INSTR_CYCLES    3'h4

`endif

// ### shared/irq_unit_pkg.sv
// Types of the two-level vectored interrupt unit.
// Assumes no other package.
package irq_unit_pkg;

    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_CALL = 1'b1
    } call_state_t;

    typedef logic [1:0] axi_resp_t;

endpackage : irq_unit_pkg

// ### hdl/irq_unit.sv
// Vectored interrupt unit with two priority levels, AXI4-Lite registers.
// Assumes a CPU core on clk_sys reporting instruction ends and returns.
`timescale 1ns/1ps
`include "irq_unit_params.svh"

module irq_unit
    import irq_unit_pkg::*;
#(
    parameter int NUM_SRC = 16
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                ce,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_awaddr,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [7:0]          s_araddr,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire logic                s_rready,
    // Sources
    input  wire logic [NUM_SRC-1:0]  src_event,
    input  wire logic                ext_irq_pin0,
    input  wire logic                ext_irq_pin1,
    // CPU side
    input  wire logic                instr_done,
    input  wire logic                next_multi_cycle,
    input  wire logic                return_from_irq_instr_done,
    output logic                     long_call_instr_busy,
    output logic                     long_call_instr_last,
    output logic [15:0]              long_call_instr_vector
);

    localparam axi_resp_t RESP_OK  = 2'h0;
    localparam axi_resp_t RESP_ERR = 2'h2;

    // Register state
    logic [7:0]         basic_irq_enable_reg_r;
    logic [7:0]         ext_irq_enable_reg_one_r;
    logic [7:0]         ext_irq_enable_reg_two_r;
    logic [7:0]         basic_irq_priority_reg_r;
    logic [7:0]         ext_irq_priority_reg_one_r;
    logic [7:0]         ext_irq_priority_reg_two_r;
    logic [NUM_SRC-1:0] pend_r;
    logic [NUM_SRC-1:0] pend_nxt;
    logic [NUM_SRC-1:0] shadow_en_r;
    logic               clr_window_r;
    logic               isr_hi_r;
    logic               isr_lo_r;
    call_state_t        state_r;
    logic [2:0]         cnt_r;
    logic [3:0]         win_idx_r;
    logic               win_hi_r;
    logic [2:0]         pin0_sync_r;
    logic [2:0]         pin1_sync_r;

    // Falling edges on the active-low pins; stage 0 only feeds stage 1
    wire pin0_fall = pin0_sync_r[2] & ~pin0_sync_r[1];
    wire pin1_fall = pin1_sync_r[2] & ~pin1_sync_r[1];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin0_sync_r <= 3'h7;
            pin1_sync_r <= 3'h7;
        end else if (ce) begin
            pin0_sync_r <= {pin0_sync_r[1:0], ext_irq_pin0};
            pin1_sync_r <= {pin1_sync_r[1:0], ext_irq_pin1};
        end
    end

    // Bus decode
    wire wr_go     = s_awvalid & s_wvalid & ~s_bvalid & ce;
    wire rd_go     = s_arvalid & ~s_rvalid & ce;
    wire wr_en_b   = wr_go & s_wstrb[0];
    wire wr_en_h   = wr_go & s_wstrb[1];
    wire [7:0] wd  = s_wdata[7:0];
    wire a_ben     = s_awaddr == `OFS_BASIC_EN;
    wire a_een1    = s_awaddr == `OFS_EXT_EN_ONE;
    wire a_een2    = s_awaddr == `OFS_EXT_EN_TWO;
    wire a_bpri    = s_awaddr == `OFS_BASIC_PRI;
    wire a_epri1   = s_awaddr == `OFS_EXT_PRI_ONE;
    wire a_epri2   = s_awaddr == `OFS_EXT_PRI_TWO;
    wire a_pend    = s_awaddr == `OFS_PENDING;
    wire a_stat    = s_awaddr == `OFS_STATUS;
    wire wr_hit    = a_ben | a_een1 | a_een2 | a_bpri | a_epri1
                   | a_epri2 | a_pend | a_stat;

    assign s_awready = wr_go;
    assign s_wready  = wr_go;
    assign s_arready = rd_go;

    // Orders 0-6 in basic, 7-14 in extended one; 8 and 15 are holes
    wire [NUM_SRC-1:0] rsvd_mask = ~(16'h0001 << `RSVD_ORDER_A)
                                 & ~(16'h0001 << `RSVD_ORDER_B);
    wire [NUM_SRC-1:0] en_vec  = {1'b0, ext_irq_enable_reg_one_r,
                                  basic_irq_enable_reg_r[6:0]};
    wire [NUM_SRC-1:0] pri_vec = {1'b0, ext_irq_priority_reg_one_r,
                                  basic_irq_priority_reg_r[6:0]};
    wire               glob_en = basic_irq_enable_reg_r[`GLOBAL_EN_BIT];

    // Enables just cleared by a write: the old set lives one more
    // instruction unless a multi-cycle one follows
    wire [NUM_SRC-1:0] eff_en = (clr_window_r & ~next_multi_cycle)
                              ? shadow_en_r : en_vec;
    wire [NUM_SRC-1:0] live = pend_r & eff_en & rsvd_mask;
    wire               gate = clr_window_r & ~next_multi_cycle
                              ? shadow_en_r[NUM_SRC-1] | glob_en : glob_en;
    wire [NUM_SRC-1:0] req_hi = live & pri_vec & {NUM_SRC{gate}};
    wire [NUM_SRC-1:0] req_lo = live & ~pri_vec & {NUM_SRC{gate}};

    // Lowest order wins within a level
    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    always_comb begin
        hi_idx = 4'h0;
        lo_idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_hi[i]) begin
                hi_idx = 4'(i);
            end
            if (req_lo[i]) begin
                lo_idx = 4'(i);
            end
        end
    end

    wire any_hi  = |req_hi;
    wire any_lo  = |req_lo;
    wire ok_hi   = any_hi & ~isr_hi_r;
    wire ok_lo   = any_lo & ~isr_hi_r & ~isr_lo_r;
    // Return cycle never takes: one more instruction must finish first
    wire take    = ce & (state_r == ST_RUN) & instr_done & ~return_from_irq_instr_done
                 & (ok_hi | ok_lo);
    wire [3:0] take_idx = ok_hi ? hi_idx : lo_idx;
    wire call_end = ce & (state_r == ST_CALL)
                  & (cnt_r == `LONG_CALL_INSTR_CYCLES - 3'h1);

    // Pending flags: events set, software writes, hardware clear
    logic [NUM_SRC-1:0] hw_set;
    always_comb begin
        hw_set    = src_event;
        hw_set[0] = src_event[0] | pin0_fall;
        hw_set[2] = src_event[2] | pin1_fall;
        pend_nxt  = pend_r;
        if (wr_go & a_pend) begin
            if (wr_en_b) begin
                pend_nxt[7:0] = wd;
            end
            if (wr_en_h) begin
                pend_nxt[15:8] = s_wdata[15:8];
            end
        end
        if (call_end && win_idx_r <= 4'(`HW_CLR_LAST)) begin
            pend_nxt[win_idx_r] = 1'b0;
        end
        pend_nxt = (pend_nxt | hw_set) & rsvd_mask;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_r <= `PEND_RESET;
        end else if (ce) begin
            pend_r <= pend_nxt;
        end
    end

    // Register writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            basic_irq_enable_reg_r     <= `EN_RESET;
            ext_irq_enable_reg_one_r   <= `EN_RESET;
            ext_irq_enable_reg_two_r   <= `EN_RESET;
            basic_irq_priority_reg_r   <= `PRI_RESET;
            ext_irq_priority_reg_one_r <= `PRI_RESET;
            ext_irq_priority_reg_two_r <= `PRI_RESET;
        end else if (wr_en_b) begin
            if (a_ben) basic_irq_enable_reg_r <= wd;
            if (a_een1) ext_irq_enable_reg_one_r <= wd;
            if (a_een2) ext_irq_enable_reg_two_r <= wd;
            if (a_bpri) basic_irq_priority_reg_r <= {1'b0, wd[6:0]};
            if (a_epri1) ext_irq_priority_reg_one_r <= wd;
            if (a_epri2) ext_irq_priority_reg_two_r <= wd;
        end
    end

    // Enable-clear window, closed by the next instruction end
    wire en_clearing = wr_en_b & ((a_ben & |(basic_irq_enable_reg_r & ~wd))
                     | (a_een1 & |(ext_irq_enable_reg_one_r & ~wd)));
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clr_window_r <= 1'b0;
            shadow_en_r  <= '0;
        end else if (ce) begin
            if (en_clearing) begin
                clr_window_r <= 1'b1;
                shadow_en_r  <= {glob_en, en_vec[NUM_SRC-2:0]};
            end else if (instr_done) begin
                clr_window_r <= 1'b0;
            end
        end
    end

    // Call sequencer and in-service levels
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= ST_RUN;
            cnt_r        <= 3'h0;
            win_idx_r    <= 4'h0;
            win_hi_r     <= 1'b0;
            long_call_instr_vector <= `RESET_VECTOR;
            isr_hi_r     <= 1'b0;
            isr_lo_r     <= 1'b0;
        end else if (ce) begin
            case (state_r)
                ST_RUN: begin
                    if (take) begin
                        state_r      <= ST_CALL;
                        cnt_r        <= 3'h0;
                        win_idx_r    <= take_idx;
                        win_hi_r     <= ok_hi;
                        long_call_instr_vector <= `VECTOR_BASE
                                      + {9'h000, take_idx, 3'h0};
                    end
                end
                ST_CALL: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (call_end) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
            // Return drops the highest level in service
            if (call_end) begin
                if (win_hi_r) isr_hi_r <= 1'b1;
                else isr_lo_r <= 1'b1;
            end else if (return_from_irq_instr_done) begin
                if (isr_hi_r) isr_hi_r <= 1'b0;
                else isr_lo_r <= 1'b0;
            end
        end
    end

    assign long_call_instr_busy = state_r == ST_CALL;
    assign long_call_instr_last = call_end;

    // Write response
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OK;
        end else if (ce) begin
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp  <= wr_hit ? RESP_OK : RESP_ERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read data
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_araddr)
            `OFS_BASIC_EN:    rd_mux = {24'h0, basic_irq_enable_reg_r};
            `OFS_EXT_EN_ONE:  rd_mux = {24'h0, ext_irq_enable_reg_one_r};
            `OFS_EXT_EN_TWO:  rd_mux = {24'h0, ext_irq_enable_reg_two_r};
            `OFS_BASIC_PRI:   rd_mux = {24'h0, 1'b1, basic_irq_priority_reg_r[6:0]};
            `OFS_EXT_PRI_ONE: rd_mux = {24'h0, ext_irq_priority_reg_one_r};
            `OFS_EXT_PRI_TWO: rd_mux = {24'h0, ext_irq_priority_reg_two_r};
            `OFS_PENDING:     rd_mux = {16'h0, pend_r};
            `OFS_STATUS:      rd_mux = {8'h0, long_call_instr_vector, win_idx_r,
                                        1'b0, long_call_instr_busy, isr_hi_r, isr_lo_r};
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= RESP_OK;
        end else if (ce) begin
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_mux;
                s_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    AST_CALL_LEN: assert property (@(posedge clk_sys) disable iff (!rst_b || !ce)
        take |=> long_call_instr_busy [*4] ##1 !long_call_instr_busy)
        else $error("long call not four cycles");
    AST_GATED: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take |-> eff_en[take_idx] && pend_r[take_idx] && gate)
        else $error("disabled source taken");
    AST_GLOBAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!glob_en && !clr_window_r) |-> !take)
        else $error("taken with global enable low");
    AST_VEC: assert property (@(posedge clk_sys) disable iff (!rst_b)
        long_call_instr_busy |-> long_call_instr_vector == 16'h0003 + 16'(win_idx_r) * 16'h0008
            && win_idx_r != 4'h8 && win_idx_r != 4'hF)
        else $error("wrong vector");
    AST_HI_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        isr_hi_r |-> !take)
        else $error("high routine preempted");
    AST_LO_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (take && isr_lo_r) |-> ok_hi)
        else $error("low routine preempted by equal level");
    AST_RETURN_FROM_IRQ_INSTR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        return_from_irq_instr_done |-> !take)
        else $error("call in return cycle");
    AST_PRIO: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (take && any_hi && !isr_hi_r) |-> pri_vec[take_idx]
            && (req_hi & ((16'h0001 << take_idx) - 16'h0001)) == 16'h0)
        else $error("wrong arbitration winner");
    AST_HWCLR: assert property (@(posedge clk_sys) disable iff (!rst_b || !ce)
        (call_end && win_idx_r <= 4'h3 && !hw_set[win_idx_r]
            && !(wr_go && a_pend))
        |=> !pend_r[$past(win_idx_r)])
        else $error("hardware clear missed");
    AST_SET: assert property (@(posedge clk_sys) disable iff (!rst_b || !ce)
        (|(src_event & rsvd_mask)) |=> (pend_r & $past(src_event) & rsvd_mask)
            == ($past(src_event) & rsvd_mask))
        else $error("event flag not set");
    AST_ISR: assert property (@(posedge clk_sys) disable iff (!rst_b || !ce)
        call_end |=> (win_hi_r ? isr_hi_r : isr_lo_r))
        else $error("level not marked in service");

endmodule : irq_unit

// ### tb/cpu_model.sv
// CPU core model facing the interrupt unit's instruction side.
// Assumes one clock; single-cycle instructions, core stalls during calls.
`timescale 1ns/1ps
module cpu_model (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic long_call_instr_busy,
    input  wire logic return_from_irq_instr_req,
    input  wire logic multi_cycle_req,
    output logic      instr_done,
    output logic      next_multi_cycle,
    output logic      return_from_irq_instr_done
);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            instr_done <= 1'b0;
            return_from_irq_instr_done  <= 1'b0;
        end else begin
            // Stalled core ends no instruction while the call runs
            instr_done <= !long_call_instr_busy && !return_from_irq_instr_req;
            return_from_irq_instr_done  <= return_from_irq_instr_req && !long_call_instr_busy;
        end
    end
    // Follow-up kind after an enable clear; the bench picks it per scenario
    assign next_multi_cycle = multi_cycle_req;
endmodule : cpu_model

// ### tb/two_level_vectored_interrupt_unit_test.sv
// Self-checking bench: AXI4-Lite master tasks and a CPU model.
// Assumes irq_unit with its package compiled first.
`timescale 1ns/1ps
module two_level_vectored_interrupt_unit_test
    import irq_unit_pkg::*;
;
    logic        clk_sys, rst_b, return_from_irq_instr_req;
    logic [7:0]  s_awaddr, s_araddr;
    logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rsp;
    logic [15:0] src_event, long_call_instr_vector;
    logic        ext_irq_pin0, ext_irq_pin1, instr_done, next_multi_cycle;
    logic        return_from_irq_instr_done, long_call_instr_busy, long_call_instr_last;
    logic        ce, multi_req;
    int          err_count, checks;

    irq_unit #(.NUM_SRC(16)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .src_event(src_event), .ext_irq_pin0(ext_irq_pin0), .ext_irq_pin1(ext_irq_pin1),
        .instr_done(instr_done), .next_multi_cycle(next_multi_cycle),
        .return_from_irq_instr_done(return_from_irq_instr_done), .long_call_instr_busy(long_call_instr_busy), .long_call_instr_last(long_call_instr_last),
        .long_call_instr_vector(long_call_instr_vector));
    cpu_model i_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .long_call_instr_busy(long_call_instr_busy),
        .return_from_irq_instr_req(return_from_irq_instr_req), .multi_cycle_req(multi_req), .instr_done(instr_done),
        .next_multi_cycle(next_multi_cycle), .return_from_irq_instr_done(return_from_irq_instr_done));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ao, wo;
        ao = 0;
        wo = 0;
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ao && wo && s_bvalid) break;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            ao |= s_awready;
            wo |= s_wready;
        end
        chk("bvalid", 1, s_bvalid);
        rsp = s_bresp;
    endtask : wr

    task automatic rdw(input logic [7:0] a);
        bit ao;
        ao = 0;
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (ao && s_rvalid) break;
            if (s_arready) s_arvalid <= 1'b0;
            ao |= s_arready;
        end
        chk("rvalid", 1, s_rvalid);
        rd = s_rdata;
        rsp = s_rresp;
    endtask : rdw

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rdw(a);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask : rdc

    task automatic ev(input logic [15:0] m);
        @(posedge clk_sys);
        src_event <= m;
        @(posedge clk_sys);
        src_event <= 16'h0000;
    endtask : ev

    // Busy is counted too, so a short or long call shows up here
    task automatic call(input logic [15:0] v);
        int n;
        n = 0;
        repeat (60) begin
            @(posedge clk_sys);
            n += long_call_instr_busy;
            if (long_call_instr_last) break;
        end
        chk("call vector", {16'h0001, v}, {15'h0000, long_call_instr_last, long_call_instr_vector});
        chk("call cycles", 32'h4, n);
    endtask : call

    task automatic quiet();
        int n;
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            n += long_call_instr_busy;
        end
        chk("idle busy", 0, n);
    endtask : quiet

    task automatic ret_irq();
        @(posedge clk_sys);
        return_from_irq_instr_req <= 1'b1;
        @(posedge clk_sys);
        return_from_irq_instr_req <= 1'b0;
        // Let the return land before the caller reads status
        @(posedge clk_sys);
    endtask : ret_irq

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end

    initial begin
        {s_awaddr, s_araddr, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
        {s_rready, s_wdata, src_event, return_from_irq_instr_req} = '0;
        {ce, multi_req} = 2'b10;
        s_wstrb = 4'hF;
        {ext_irq_pin0, ext_irq_pin1} = 2'b11;
        rst_b = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(8'h0C, 32'hFF, 32'h80);
        rdc(8'h10, 32'hFF, 32'h00);
        rdc(8'h1C, 32'hFFFF00, 32'h0);
        rdw(8'h40);
        chk("rresp", 2'b10, rsp);
        wr(8'h40, 32'h0);
        chk("bresp", 2'b10, rsp);
        ce <= 1'b0;
        ev(16'h0020);
        ce <= 1'b1;
        rdc(8'h18, 32'hFFFF, 32'h0);
        ev(16'h0020);
        rdc(8'h18, 32'hFFFF, 32'h20);
        quiet();
        wr(8'h00, 32'hA0);
        call(16'h002B);
        rdc(8'h18, 32'hFFFF, 32'h20);
        rdc(8'h1C, 32'h3, 32'h1);
        ret_irq();
        call(16'h002B);
        wr(8'h18, 32'h0);
        ret_irq();
        rdc(8'h1C, 32'h3, 32'h0);
        src_event <= 16'h0020;
        wr(8'h00, 32'h0);
        src_event <= 16'h0000;
        call(16'h002B);
        wr(8'h18, 32'h0);
        ret_irq();
        wr(8'h00, 32'hA0);
        multi_req <= 1'b1;
        src_event <= 16'h0020;
        wr(8'h00, 32'h0);
        src_event <= 16'h0000;
        quiet();
        rdc(8'h18, 32'hFFFF, 32'h20);
        multi_req <= 1'b0;
        wr(8'h18, 32'h0);
        wr(8'h00, 32'h0);
        ev(16'h0050);
        wr(8'h00, 32'hD0);
        call(16'h0023);
        wr(8'h18, 32'h40);
        ret_irq();
        call(16'h0033);
        wr(8'h18, 32'h0);
        ret_irq();
        wr(8'h00, 32'h0);
        wr(8'h18, 32'h50);
        wr(8'h0C, 32'h40);
        wr(8'h00, 32'hD0);
        call(16'h0033);
        rdc(8'h1C, 32'h3, 32'h2);
        quiet();
        wr(8'h18, 32'h10);
        ret_irq();
        call(16'h0023);
        wr(8'h18, 32'h50);
        call(16'h0033);
        rdc(8'h1C, 32'h3, 32'h3);
        wr(8'h18, 32'h0);
        ret_irq();
        ret_irq();
        rdc(8'h1C, 32'h3, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h82);
        ev(16'h0002);
        call(16'h000B);
        rdc(8'h18, 32'hFFFF, 32'h0);
        ret_irq();
        wr(8'h00, 32'h81);
        ext_irq_pin0 <= 1'b0;
        call(16'h0003);
        rdc(8'h18, 32'hFFFF, 32'h0);
        ret_irq();
        ext_irq_pin0 <= 1'b1;
        wr(8'h00, 32'h08);
        ev(16'h0008);
        quiet();
        rdc(8'h18, 32'hFFFF, 32'h8);
        wr(8'h00, 32'h88);
        call(16'h001B);
        rdc(8'h18, 32'hFFFF, 32'h0);
        ret_irq();
        wr(8'h00, 32'h80);
        wr(8'h04, 32'h04);
        wr(8'h18, 32'h0200);
        call(16'h004B);
        wr(8'h18, 32'h0);
        ret_irq();
        wr(8'h18, 32'h8100);
        rdc(8'h18, 32'hFFFF, 32'h0);
        stop_test();
    end
endmodule : two_level_vectored_interrupt_unit_test
